// ### src/logic_cluster.sv
// logic cluster: ten logic cells with shared controls and carry-select chains
module logic_cluster #(
   parameter int N = cluster_pkg::N_CELLS
) (
   input  wire logic                                                   ref_clk,
   input  wire logic                                                   reset_n,
   input  wire logic [cluster_pkg::N_ROW_CLOCKS-1:0]                   row_clock,
   input  wire logic [cluster_pkg::N_CTRL-1:0]                         local_ctrl,
   input  wire logic [cluster_pkg::N_CTRL-1:0]                         ctrl_from_row,
   input  wire logic [cluster_pkg::N_CTRL-1:0][cluster_pkg::ROW_IDX_W-1:0] ctrl_row_idx,
   input  wire logic                                                   clk_a_falling,
   input  wire logic                                                   clk_b_falling,
   input  wire logic                                                   both_edges,
   input  wire logic                                                   device_wide_clear_n,
   input  wire logic                                                   dev_clr_enable,
   input  wire logic [N-1:0][cluster_pkg::LUT_INPUTS-1:0]              cell_data,
   input  wire logic [N-1:0][cluster_pkg::LUT_BITS-1:0]                lut_mask,
   input  cluster_pkg::reg_mode_e [N-1:0]                              reg_mode,
   input  wire logic [N-1:0]                                           arith_mode,
   input  wire logic [N-1:0]                                           counter_mode,
   input  wire logic [N-1:0]                                           chain_end,
   input  wire logic [N-1:0]                                           lut3_from_carry,
   input  wire logic [N-1:0]                                           reg_feedback,
   input  wire logic [N-1:0]                                           lut_chain_en,
   input  wire logic [N-1:0]                                           reg_chain_en,
   input  wire logic [N-1:0]                                           clk_sel_b,
   input  wire logic [N-1:0][1:0]                                      clr_sel,
   input  wire logic [N-1:0][cluster_pkg::N_OUTS-1:0]                  out_sel,
   input  wire logic                                                   cluster_carry_in,
   input  wire logic                                                   lut_chain_in,
   input  wire logic                                                   reg_chain_in,
   output logic      [N-1:0][cluster_pkg::N_OUTS-1:0]                  cell_out,
   output logic                                                        cluster_carry_out,
   output logic                                                        lut_chain_out,
   output logic                                                        reg_chain_out
);
   cluster_ctrl_if ctl ();

   // one control generator serves every cell
   cluster_ctrl_gen u_ctrl (
      .ref_clk             (ref_clk),
      .reset_n             (reset_n),
      .row_clock           (row_clock),
      .local_ctrl          (local_ctrl),
      .ctrl_from_row       (ctrl_from_row),
      .ctrl_row_idx        (ctrl_row_idx),
      .clk_a_falling       (clk_a_falling),
      .clk_b_falling       (clk_b_falling),
      .both_edges          (both_edges),
      .device_wide_clear_n (device_wide_clear_n),
      .dev_clr_enable      (dev_clr_enable),
      .ctl                 (ctl)
   );

   logic [N:0]   zero_chain_carry;
   logic [N:0]   one_chain_carry;
   logic [N:0]   lut_chain;
   logic [N:0]   reg_chain;
   logic [N-1:0] invert_b;

   // lsb cell: subtraction forces the carry into the zero chain high; the one chain always starts high
   assign zero_chain_carry[0] = invert_b[0];
   assign one_chain_carry[0]  = cluster_pkg::FIRST_ONE_CARRY;
   assign lut_chain[0]        = lut_chain_in;
   assign reg_chain[0]        = reg_chain_in;

   for (genvar i = 0; i < N; i++) begin : g_cell
      logic                                first_data_input;
      logic                                second_data_input;
      logic                                third_data_input;
      logic                                fourth_data_input;
      logic                                b_op;
      logic                                lut_in0;
      logic                                lut_in3;
      logic                                chain_sel;
      logic                                lut_res;
      logic                                sum0;
      logic                                sum1;
      logic                                sum_sel;
      logic                                comb_res;
      logic                                d_src;
      logic                                count_hold;
      logic                                tick;
      logic                                aclr;
      logic                                fn_next;
      logic                                q_q;

      assign first_data_input  = cell_data[i][0];
      assign second_data_input = cell_data[i][1];
      assign third_data_input  = cell_data[i][2];
      assign fourth_data_input = cell_data[i][3];

      // addnsub reaches normal-mode cells only at a chain end
      assign invert_b[i] = (ctl.addnsub & (arith_mode[i] | chain_end[i]))
                         ^ (counter_mode[i] & arith_mode[i] & ~fourth_data_input);
      assign b_op = second_data_input ^ invert_b[i];

      // level of the chain picked by the cluster carry-in
      assign chain_sel = cluster_carry_in ? one_chain_carry[i] : zero_chain_carry[i];

      assign lut_in0 = lut_chain_en[i] ? lut_chain[i] : first_data_input;
      assign lut_in3 = reg_feedback[i] ? q_q
                     : (lut3_from_carry[i] ? chain_sel : fourth_data_input);
      assign lut_res = lut_mask[i][{lut_in3, third_data_input, b_op, lut_in0}];

      // both sums precomputed so only the select sits on the slow path
      assign sum0 = first_data_input ^ b_op ^ zero_chain_carry[i];
      assign sum1 = first_data_input ^ b_op ^ one_chain_carry[i];
      assign sum_sel = cluster_carry_in ? sum1 : sum0;
      assign zero_chain_carry[i+1] = (first_data_input & b_op)
                                   | (zero_chain_carry[i] & (first_data_input ^ b_op));
      assign one_chain_carry[i+1]  = (first_data_input & b_op)
                                   | (one_chain_carry[i] & (first_data_input ^ b_op));

      assign comb_res = arith_mode[i] ? sum_sel : lut_res;
      assign lut_chain[i+1] = comb_res;

      // shift path skips the table so the table stays free
      assign d_src = reg_chain_en[i] ? reg_chain[i] : comb_res;
      assign count_hold = counter_mode[i] & arith_mode[i] & ~third_data_input;

      assign tick = clk_sel_b[i] ? ctl.tick_b : ctl.tick_a;
      assign aclr = ((clr_sel[i] == cluster_pkg::CLR_A) & ctl.clr_a)
                  | ((clr_sel[i] == cluster_pkg::CLR_B) & ctl.clr_b);

      // third input doubles as K or R for the two-input modes
      always_comb begin
         case (reg_mode[i])
            cluster_pkg::REG_D:  fn_next = d_src;
            cluster_pkg::REG_T:  fn_next = q_q ^ d_src;
            cluster_pkg::REG_JK: fn_next = (d_src & ~q_q) | (~third_data_input & q_q);
            cluster_pkg::REG_SR: fn_next = d_src | (q_q & ~third_data_input);
            default:             fn_next = d_src;
         endcase
      end

      // async controls act on the next ref_clk edge, ahead of any tick
      always_ff @(posedge ref_clk or negedge reset_n) begin
         if (!reset_n) begin
            q_q <= cluster_pkg::REG_RESET_VAL;
         end else if (ctl.dev_clr) begin
            q_q <= cluster_pkg::REG_RESET_VAL;
         end else if (aclr) begin
            q_q <= cluster_pkg::REG_RESET_VAL;
         end else if (ctl.aload) begin
            q_q <= fourth_data_input;
         end else if (tick) begin
            if (ctl.sclr) begin
               q_q <= cluster_pkg::REG_RESET_VAL;
            end else if (ctl.sload) begin
               q_q <= fourth_data_input;
            end else if (!count_hold) begin
               q_q <= fn_next;
            end
         end
      end

      assign reg_chain[i+1] = q_q;

      for (genvar k = 0; k < cluster_pkg::N_OUTS; k++) begin : g_out
         // unregistered path kept combinational, the bypass is its point
         assign cell_out[i][k] = out_sel[i][k] ? q_q : comb_res;
      end
   end

   assign cluster_carry_out = cluster_carry_in ? one_chain_carry[N] : zero_chain_carry[N];
   assign lut_chain_out     = lut_chain[N];
   assign reg_chain_out     = reg_chain[N];
endmodule // logic_cluster

// ### common/cluster_pkg.sv
// shared constants and types for the logic cluster
package cluster_pkg;
   localparam int N_CELLS      = 10;
   localparam int N_ROW_CLOCKS = 8;
   localparam int N_CTRL       = 10;
   localparam int LUT_INPUTS   = 4;
   localparam int LUT_BITS     = 16;
   localparam int N_OUTS       = 3;
   localparam int ROW_IDX_W    = 3;
   // positions of the cluster-wide controls in the source select vectors
   localparam int CTRL_CLK_A   = 0;
   localparam int CTRL_CLK_B   = 1;
   localparam int CTRL_GATE_A  = 2;
   localparam int CTRL_GATE_B  = 3;
   localparam int CTRL_CLR_A   = 4;
   localparam int CTRL_CLR_B   = 5;
   localparam int CTRL_ALOAD   = 6;
   localparam int CTRL_SCLR    = 7;
   localparam int CTRL_SLOAD   = 8;
   localparam int CTRL_ADDNSUB = 9;
   // cell register clear selection
   localparam logic [1:0] CLR_NONE = 2'h0;
   localparam logic [1:0] CLR_A    = 2'h1;
   localparam logic [1:0] CLR_B    = 2'h2;
   localparam logic       REG_RESET_VAL = 1'h0;
   localparam logic       FIRST_ONE_CARRY = 1'h1;
   typedef enum logic [1:0] {
      REG_D,
      REG_T,
      REG_JK,
      REG_SR
   } reg_mode_e;
endpackage

// ### common/cluster_ctrl_if.sv
// cluster-wide control signals shared by all cells
interface cluster_ctrl_if;
   logic tick_a;
   logic tick_b;
   logic clr_a;
   logic clr_b;
   logic aload;
   logic sclr;
   logic sload;
   logic addnsub;
   logic dev_clr;
   modport gen (
      output tick_a,
      output tick_b,
      output clr_a,
      output clr_b,
      output aload,
      output sclr,
      output sload,
      output addnsub,
      output dev_clr
   );
   modport cells (
      input tick_a,
      input tick_b,
      input clr_a,
      input clr_b,
      input aload,
      input sclr,
      input sload,
      input addnsub,
      input dev_clr
   );
endinterface

// ### src/cluster_ctrl_gen.sv
// generation of cluster-wide controls from row clocks and local routing
module cluster_ctrl_gen (
   input  wire logic                                                   ref_clk,
   input  wire logic                                                   reset_n,
   input  wire logic [cluster_pkg::N_ROW_CLOCKS-1:0]                   row_clock,
   input  wire logic [cluster_pkg::N_CTRL-1:0]                         local_ctrl,
   input  wire logic [cluster_pkg::N_CTRL-1:0]                         ctrl_from_row,
   input  wire logic [cluster_pkg::N_CTRL-1:0][cluster_pkg::ROW_IDX_W-1:0] ctrl_row_idx,
   input  wire logic                                                   clk_a_falling,
   input  wire logic                                                   clk_b_falling,
   input  wire logic                                                   both_edges,
   input  wire logic                                                   device_wide_clear_n,
   input  wire logic                                                   dev_clr_enable,
   cluster_ctrl_if.gen                                                 ctl
);
   logic [cluster_pkg::N_ROW_CLOCKS-1:0] row_q;
   logic [cluster_pkg::N_CTRL-1:0]       local_q;
   logic [cluster_pkg::N_CTRL-1:0]       src;
   logic                                 clk_b_src;
   logic                                 clk_b_fall;
   logic                                 prev_a_q;
   logic                                 prev_b_q;
   logic                                 edge_a;
   logic                                 edge_b;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         row_q   <= '0;
         local_q <= '0;
      end else begin
         row_q   <= row_clock;
         local_q <= local_ctrl;
      end
   end

   for (genvar k = 0; k < cluster_pkg::N_CTRL; k++) begin : g_src
      assign src[k] = ctrl_from_row[k] ? row_q[ctrl_row_idx[k]] : local_q[k];
   end

   // both edges of one clock take both cluster clocks
   assign clk_b_src  = both_edges ? src[cluster_pkg::CTRL_CLK_A] : src[cluster_pkg::CTRL_CLK_B];
   assign clk_b_fall = both_edges ? ~clk_a_falling : clk_b_falling;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         prev_a_q <= 1'h0;
         prev_b_q <= 1'h0;
      end else begin
         prev_a_q <= src[cluster_pkg::CTRL_CLK_A];
         prev_b_q <= clk_b_src;
      end
   end

   assign edge_a = clk_a_falling ? (prev_a_q & ~src[cluster_pkg::CTRL_CLK_A])
                                 : (~prev_a_q & src[cluster_pkg::CTRL_CLK_A]);
   assign edge_b = clk_b_fall ? (prev_b_q & ~clk_b_src) : (~prev_b_q & clk_b_src);

   // each clock only ever travels with its own gate
   assign ctl.tick_a  = edge_a & src[cluster_pkg::CTRL_GATE_A];
   assign ctl.tick_b  = edge_b & src[cluster_pkg::CTRL_GATE_B];
   assign ctl.clr_a   = src[cluster_pkg::CTRL_CLR_A];
   assign ctl.clr_b   = src[cluster_pkg::CTRL_CLR_B];
   assign ctl.aload   = src[cluster_pkg::CTRL_ALOAD];
   assign ctl.sclr    = src[cluster_pkg::CTRL_SCLR];
   assign ctl.sload   = src[cluster_pkg::CTRL_SLOAD];
   assign ctl.addnsub = src[cluster_pkg::CTRL_ADDNSUB];
   assign ctl.dev_clr = dev_clr_enable & ~device_wide_clear_n;
endmodule // cluster_ctrl_gen

// ### sim/cluster_neighbour.sv
// upstream neighbour model driving the cluster chain inputs
module cluster_neighbour (
   input  wire logic       ref_clk,
   input  wire logic       reset_n,
   input  wire logic [2:0] want,
   output logic            carry_in,
   output logic            lut_in,
   output logic            reg_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // launched on the falling edge, well clear of the cluster's sampling edge
   always_ff @(negedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         {carry_in, lut_in, reg_in} <= 3'h0;
      end else begin
         {carry_in, lut_in, reg_in} <= want;
      end
   end
endmodule // cluster_neighbour

// ### sim/logic_cluster_assertions.sv
// port-level assertions for the logic cluster
module logic_cluster_assertions #(
   parameter int N = cluster_pkg::N_CELLS
) (
   input wire logic                  ref_clk,
   input wire logic                  reset_n,
   input wire logic [9:0]            local_ctrl,
   input wire logic [9:0]            ctrl_from_row,
   input wire logic                  device_wide_clear_n,
   input wire logic                  dev_clr_enable,
   input wire logic [N-1:0][3:0]     cell_data,
   input wire logic [N-1:0][15:0]    lut_mask,
   input wire logic [N-1:0]          arith_mode,
   input wire logic [N-1:0]          counter_mode,
   input wire logic [N-1:0]          chain_end,
   input wire logic [N-1:0]          lut3_from_carry,
   input wire logic [N-1:0]          reg_feedback,
   input wire logic [N-1:0]          lut_chain_en,
   input wire logic [N-1:0]          clk_sel_b,
   input wire logic [N-1:0][1:0]     clr_sel,
   input wire logic [N-1:0][2:0]     out_sel,
   input wire logic                  cluster_carry_in,
   input wire logic [N-1:0][2:0]     cell_out,
   input wire logic                  cluster_carry_out,
   input wire logic                  lut_chain_out,
   input wire logic                  reg_chain_out
);
   logic [N-1:0] a_v, b_v, r_v, o_v;
   logic [N:0]   e_v;
   logic         dev_on, quiet, add_cfg, plain, clr_on, pre_ok, gate_off;
   always_comb begin
      for (int i = 0; i < N; i++) begin
         a_v[i] = cell_data[i][0];
         b_v[i] = cell_data[i][1];
         r_v[i] = cell_out[i][0];
         o_v[i] = out_sel[i][0];
      end
   end
   // subtract: inverted b plus a forced one at the lsb
   assign e_v = {1'h0, a_v} + {1'h0, local_ctrl[9] ? ~b_v : b_v} + (N+1)'(local_ctrl[9] | cluster_carry_in);
   assign dev_on = dev_clr_enable && !device_wide_clear_n;
   assign quiet = !dev_on && !(|ctrl_from_row[6:4]) && !(|local_ctrl[6:4]);
   assign add_cfg = &arith_mode && !(|counter_mode) && !(|o_v) && !ctrl_from_row[9];
   assign plain = !arith_mode[N-1] && !chain_end[N-1] && !lut3_from_carry[N-1] && !reg_feedback[N-1]
                  && !lut_chain_en[N-1];
   assign clr_on = (clr_sel[N-1] == cluster_pkg::CLR_A && local_ctrl[4] && !ctrl_from_row[4])
                   || (clr_sel[N-1] == cluster_pkg::CLR_B && local_ctrl[5] && !ctrl_from_row[5]);
   assign pre_ok = !dev_on && !(|ctrl_from_row[6:4]) && local_ctrl[6:4] == 3'h4 && cell_data[N-1][3];
   assign gate_off = quiet && !clk_sel_b[N-1] && !ctrl_from_row[2] && !local_ctrl[2];
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   arith_sum_a: assert property ((add_cfg && $stable(local_ctrl[9]))[*2] |-> {cluster_carry_out, r_v} == e_v)
      else $error("arithmetic result wrong");
   table_read_a: assert property (plain |-> lut_chain_out == lut_mask[N-1][cell_data[N-1]])
      else $error("table output wrong");
   comb_bypass_a: assert property (!out_sel[N-1][0] |-> cell_out[N-1][0] == lut_chain_out)
      else $error("combinational output wrong");
   reg_output_a: assert property (out_sel[N-1][2] |-> cell_out[N-1][2] == reg_chain_out)
      else $error("registered output wrong");
   dev_clear_a: assert property (dev_on[*2] |=> !reg_chain_out)
      else $error("device clear ignored");
   clear_wins_a: assert property ((clr_on && local_ctrl[6] && !ctrl_from_row[6])[*2] |=> !reg_chain_out)
      else $error("clear lost to load");
   preset_load_a: assert property (pre_ok[*2] |=> reg_chain_out)
      else $error("preset not applied");
   gate_off_a: assert property (gate_off[*2] |=> $stable(reg_chain_out))
      else $error("register moved with gate off");
endmodule // logic_cluster_assertions

bind logic_cluster logic_cluster_assertions #(.N(N)) logic_cluster_assertions_inst (.ref_clk, .reset_n,
   .local_ctrl, .ctrl_from_row, .device_wide_clear_n, .dev_clr_enable, .cell_data, .lut_mask, .arith_mode,
   .counter_mode, .chain_end, .lut3_from_carry, .reg_feedback, .lut_chain_en, .clk_sel_b, .clr_sel, .out_sel,
   .cluster_carry_in, .cell_out, .cluster_carry_out, .lut_chain_out, .reg_chain_out);

// ### sim/logic_cluster_tb.sv
// self-checking bench for the logic cluster
module logic_cluster_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int N = cluster_pkg::N_CELLS;
   logic                           ref_clk, reset_n, clk_a_falling, clk_b_falling, both_edges, c;
   logic                           device_wide_clear_n, dev_clr_enable, cluster_carry_in, lut_chain_in;
   logic                           reg_chain_in, cluster_carry_out, lut_chain_out, reg_chain_out;
   logic [7:0]                     row_clock;
   logic [9:0]                     local_ctrl, ctrl_from_row;
   logic [9:0][2:0]                ctrl_row_idx;
   logic [N-1:0][3:0]              cell_data;
   logic [N-1:0][15:0]             lut_mask;
   cluster_pkg::reg_mode_e [N-1:0] reg_mode;
   logic [N-1:0]                   arith_mode, counter_mode, chain_end, lut3_from_carry, reg_feedback;
   logic [N-1:0]                   lut_chain_en, reg_chain_en, clk_sel_b, a, b, q, o;
   logic [N-1:0][1:0]              clr_sel;
   logic [N-1:0][2:0]              out_sel, cell_out;
   logic [2:0]                     want, ra, rb;
   logic [63:0]                    r;
   int                             seed = 32'h0000_ca54;
   int                             n_fail = 0;
   int                             tests_run = 0;
   logic_cluster #(.N(N)) logic_cluster_inst (.ref_clk, .reset_n, .row_clock, .local_ctrl, .ctrl_from_row,
      .ctrl_row_idx, .clk_a_falling, .clk_b_falling, .both_edges, .device_wide_clear_n, .dev_clr_enable,
      .cell_data, .lut_mask, .reg_mode, .arith_mode, .counter_mode, .chain_end, .lut3_from_carry, .reg_feedback,
      .lut_chain_en, .reg_chain_en, .clk_sel_b, .clr_sel, .out_sel, .cluster_carry_in, .lut_chain_in,
      .reg_chain_in, .cell_out, .cluster_carry_out, .lut_chain_out, .reg_chain_out);
   cluster_neighbour cluster_neighbour_inst (.ref_clk, .reset_n, .want, .carry_in(cluster_carry_in),
      .lut_in(lut_chain_in), .reg_in(reg_chain_in));
   initial ref_clk = 1'h0;
   always #25 ref_clk = ~ref_clk;
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic waitn(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   // edge seen two cycles late, so three cycles each way leaves margin
   task automatic tick(input logic [2:0] k);
      row_clock[k] = 1'h1;
      waitn(3);
      row_clock[k] = 1'h0;
      waitn(3);
   endtask
   task automatic pulse(input logic [9:0] m);
      local_ctrl = local_ctrl | m;
      waitn(3);
      local_ctrl = local_ctrl & ~m;
      waitn(3);
   endtask
   task automatic regs(input logic [N-1:0] e);
      for (int i = 0; i < N; i++) o[i] = cell_out[i][2];
      check(16'(o), 16'(e));
      check(16'(reg_chain_out), 16'(e[N-1]));
   endtask
   task automatic combs(input logic [N-1:0] e);
      for (int i = 0; i < N; i++) o[i] = cell_out[i][1];
      check(16'(o), 16'(e));
   endtask
   task automatic base;
      {cell_data, lut_mask, arith_mode, counter_mode, chain_end, lut3_from_carry, reg_feedback, lut_chain_en,
       reg_chain_en, clk_sel_b, clr_sel, out_sel, local_ctrl, ctrl_row_idx, row_clock, want} = '0;
      {clk_a_falling, clk_b_falling, both_edges, dev_clr_enable} = 4'h0;
      for (int i = 0; i < N; i++) reg_mode[i] = cluster_pkg::REG_D;
      device_wide_clear_n = 1'h1;
      ctrl_from_row = 10'h003;
      ctrl_row_idx[0] = ra;
      ctrl_row_idx[1] = rb;
      local_ctrl[3:2] = 2'h3;
   endtask
   function automatic logic [N:0] add_ref(input logic [N-1:0] x, input logic [N-1:0] y, input logic s, input logic ci);
      return {1'h0, x} + {1'h0, s ? ~y : y} + (N+1)'(s | ci);
   endfunction
   initial begin
      // about five times the expected run
      waitn(4000);
      n_fail++;
      stop_test();
   end
   initial begin
      ra = 3'($random(seed));
      rb = ra + 3'h1;
      reset_n = 1'h0;
      base();
      waitn(3);
      reset_n = 1'h1;
      for (int t = 0; t < 30; t++) begin
         r = {$random(seed), $random(seed)};
         want = r[2:0];
         lut_chain_en = N'(r >> 3);
         for (int i = 0; i < N; i++) {cell_data[i], lut_mask[i]} = 20'($random(seed));
         waitn(2);
         c = lut_chain_in;
         for (int i = 0; i < N; i++) begin
            c = lut_mask[i][{cell_data[i][3:1], lut_chain_en[i] ? c : cell_data[i][0]}];
            check(16'(cell_out[i][1:0]), {14'h0000, c, c});
         end
         check(16'(lut_chain_out), 16'(c));
      end
      base();
      reg_chain_en = '1;
      out_sel = {N{3'h4}};
      q = '0;
      r = {$random(seed), $random(seed)};
      for (int t = 0; t < 8; t++) begin
         want = {2'h0, r[t]};
         tick(ra);
         q = {q[N-2:0], r[t]};
         regs(q);
      end
      local_ctrl[2] = 1'h0;
      tick(ra);
      regs(q);
      clk_sel_b = '1;
      want = 3'h1;
      tick(rb);
      q = {q[N-2:0], 1'h1};
      regs(q);
      local_ctrl[3:2] = 2'h1;
      tick(rb);
      tick(ra);
      regs(q);
      clk_sel_b = '0;
      local_ctrl[3:2] = 2'h3;
      a = N'($random(seed));
      for (int i = 0; i < N; i++) cell_data[i][3] = a[i];
      local_ctrl[8] = 1'h1;
      tick(ra);
      regs(a);
      local_ctrl[7] = 1'h1;
      tick(ra);
      regs('0);
      local_ctrl[8:7] = 2'h0;
      for (int i = 0; i < N; i++) cell_data[i][3] = 1'h1;
      pulse(10'h040);
      regs('1);
      clr_sel = {N{2'h2}};
      pulse(10'h060);
      regs('0);
      pulse(10'h040);
      device_wide_clear_n = 1'h0;
      waitn(3);
      regs('1);
      dev_clr_enable = 1'h1;
      pulse(10'h040);
      regs('0);
      base();
      arith_mode = '1;
      for (int t = 0; t < 40; t++) begin
         a = N'($random(seed));
         b = (t < 3) ? a : N'($random(seed));
         r = 64'($random(seed));
         local_ctrl[9] = r[0];
         want = {r[1], 2'h0};
         for (int i = 0; i < N; i++) cell_data[i][1:0] = {b[i], a[i]};
         waitn(3);
         for (int i = 0; i < N; i++) o[i] = cell_out[i][0];
         check(16'({cluster_carry_out, o}), 16'(add_ref(a, b, r[0], r[1])));
      end
      // toggle register on rising clock A, both-edge clock B and falling clock A, then packing and carry-fed table
      base();
      lut_mask = {N{16'hffff}};
      for (int i = 0; i < N; i++) reg_mode[i] = cluster_pkg::REG_T;
      out_sel = {N{3'h4}};
      tick(ra);
      regs('1);
      both_edges = 1'h1;
      clk_sel_b = '1;
      tick(ra);
      regs('0);
      both_edges = 1'h0;
      clk_sel_b = '0;
      clk_a_falling = 1'h1;
      tick(ra);
      regs('1);
      // fourth inputs are low, so only the fed-back register can give ones
      lut_mask = {N{16'hff00}};
      reg_feedback = '1;
      out_sel = '0;
      waitn(1);
      regs('1);
      reg_feedback = '0;
      lut3_from_carry = '1;
      want = 3'h4;
      waitn(2);
      combs(N'(16'h0001));
      // table passes b only: addnsub must reach chain-end cells alone
      lut3_from_carry = '0;
      lut_mask = {N{16'hcccc}};
      a = N'($random(seed));
      chain_end = a;
      local_ctrl[9] = 1'h1;
      waitn(2);
      combs(a);
      base();
      arith_mode = '1;
      counter_mode = '1;
      out_sel = {N{3'h4}};
      for (int i = 0; i < N; i++) cell_data[i][3] = 1'h1;
      tick(ra);
      regs('1);
      for (int i = 0; i < N; i++) cell_data[i][2] = 1'h1;
      tick(ra);
      regs('0);
      // random soak judged by the checker, with one reset in mid-run
      for (int t = 0; t < 400; t++) begin
         r = {$random(seed), $random(seed)};
         {ctrl_row_idx, local_ctrl, ctrl_from_row, row_clock} = r[57:0];
         {clk_a_falling, clk_b_falling, both_edges, dev_clr_enable, want} = r[63:57];
         device_wide_clear_n = r[40];
         reset_n = 1'(t != 200);
         for (int i = 0; i < N; i++) begin
            r = {$random(seed), $random(seed)};
            {cell_data[i], lut_mask[i], arith_mode[i], counter_mode[i], chain_end[i], lut3_from_carry[i],
             reg_feedback[i], lut_chain_en[i], reg_chain_en[i], clk_sel_b[i], clr_sel[i], out_sel[i]} = r[32:0];
            reg_mode[i] = cluster_pkg::reg_mode_e'(r[34:33]);
         end
         waitn(1);
      end
      stop_test();
   end
endmodule // logic_cluster_tb
